// *** rtl/nov_params.svh ***
// constants of the residual overvoltage stage: offsets, fields, codes, defaults, timing
`ifndef NOV_PARAMS_SVH
`define NOV_PARAMS_SVH
`define CLK_FREQ_HZ    32'h05F5_E100
`define TICK_TIME_MS   32'h0000_0005
`define TICK_CYCLES    (`CLK_FREQ_HZ / 32'h0000_03E8 * `TICK_TIME_MS)
`define OFS_MODE       8'h00
`define OFS_FORCE      8'h04
`define OFS_SRC        8'h08
`define OFS_CFG        8'h0C
`define OFS_DLY_TYPE   8'h10
`define OFS_DLY        8'h14
`define OFS_KDIAL      8'h18
`define OFS_STATUS     8'h1C
`define OFS_RATIO      8'h20
`define OFS_REMAIN     8'h24
`define OFS_EXPECT     8'h28
`define OFS_ISTAT      8'h2C
`define OFS_IMASK      8'h30
`define THR_PAGE       3'h2
`define CFG_CH3_RES    0
`define CFG_CH4_RES    1
`define CFG_LN_CONN    2
`define CFG_FORCE_EN   3
`define MODE_ON        3'h0
`define MODE_BLOCKED   3'h1
`define MODE_TEST      3'h2
`define MODE_TEST_BLK  3'h3
`define MODE_OFF       3'h4
`define FORCE_NORMAL   2'h0
`define FORCE_START    2'h1
`define FORCE_TRIP     2'h2
`define FORCE_BLOCKED  2'h3
`define SRC_AUTO       2'h0
`define SRC_CALC       2'h1
`define SRC_CH3        2'h2
`define SRC_CH4        2'h3
`define SRC_NONE       2'h0
`define THR_DEF        16'h07D0
`define THR_MIN        16'h0064
`define THR_MAX        16'h26AC
`define RESET_PCT      24'h00_0061
`define FULL_PCT       24'h00_0064
`define DLY_DEF        20'h0_0008
`define K_DEF          16'h0005
`define K_TO_STEPS     24'h00_0002
`define RATIO_MAX      24'h00_61A8
`define MAX_STEPS      24'h05_7E40
`define IRQ_START      0
`define IRQ_TRIP       1
`define IRQ_BLOCK      2
`define IRQ_NORES      3
`endif

// *** rtl/nov_pkg.sv ***
// types shared by the residual overvoltage stage
package nov_pkg;
  typedef struct packed {
    logic signed [15:0] ph_l1;
    logic signed [15:0] ph_l2;
    logic signed [15:0] ph_l3;
    logic        [15:0] ch3;
    logic        [15:0] ch4;
  } meas_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;
  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_TRIPPED} stage_state_t;
endpackage

// *** rtl/residual_overvoltage_stage.sv ***
// residual overvoltage pick-up stage with register port and interrupt
// What this block does
// - calculated source is one third of the three phase voltage sum
// - takes residual and three phase fundamentals, refreshed every 5 ms
// - scaling: full earth fault reads 100 percent of nominal
// - static source choice: auto, calculated, third or fourth channel; auto default
// - third or fourth channel choice accepted only if channel is residual mode
// - pick up when magnitude exceeds threshold; ratio computed unless mode off or no source, else zero
// - release below 97 percent of threshold, or at once with mode off or no source
// - threshold in 0.01 percent steps, default 20 percent
// - modes on, blocked, test, test-blocked, off; on default; readback
// - forcing, when enabled, overrides status: normal, start, trip, blocked
// - mode, force and source are static, untouched by group change
// - threshold belongs to setting group, timing is one shared copy; both changeable live
// - auto picks calculated with phase voltages, else third then fourth residual channel, else flags no residual
// - ratio readout in hundredths
// - remaining time to trip in 5 ms steps while counting
`timescale 1ns/1ps
`include "nov_params.svh"
module residual_overvoltage_stage #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // register port
  input  wire nov_pkg::bus_req_t i_bus,
  output logic [31:0]            o_rdata,
  // measurement front end
  input  wire nov_pkg::meas_t    i_meas,
  input  wire logic              i_meas_valid,
  // active setting group
  input  wire logic [2:0]        i_active_group,
  // stage status
  output logic                   o_start,
  output logic                   o_trip,
  output logic                   o_blocked,
  output logic                   o_test,
  output logic                   o_no_residual,
  output logic                   o_irq
);
  logic [31:0]           tick_cnt_r;
  logic                  tick_r;
  nov_pkg::meas_t        meas_r;
  logic [2:0]            mode_r;
  logic [1:0]            force_r;
  logic [1:0]            src_sel_r;
  logic [3:0]            cfg_r;
  logic                  dly_type_r;
  logic [19:0]           dly_r;
  logic [15:0]           k_r;
  logic [15:0]           thr_r [8];
  logic [3:0]            istat_r;
  logic [3:0]            imask_r;
  logic                  pick_r;
  logic [15:0]           ratio_r;
  logic [19:0]           remain_r;
  logic [19:0]           elapsed_r;
  logic [1:0]            src_now_r;
  nov_pkg::stage_state_t state_r;
  logic signed [17:0]    sum3;
  logic signed [17:0]    calc_s;
  logic [15:0]           calc_mag;
  logic [1:0]            src_eff;
  logic [15:0]           meas_mag;
  logic [15:0]           thr_act;
  logic [15:0]           rel_lvl;
  logic                  run_ok;
  logic                  blk_mode;
  logic                  forced;
  logic                  pick_nxt;
  logic [23:0]           ratio_full;
  logic [23:0]           idmt_q;
  logic [19:0]           expect_nxt;
  logic                  start_nxt;
  logic                  trip_nxt;
  logic                  blocked_nxt;
  logic [3:0]            ev;
  logic                  wr_thr;
  logic                  thr_ok;
  logic                  src_ok;
  logic [31:0]           rd_val;

  // processing tick, counted here since the front end gives no frame signal
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end
    else if (tick_cnt_r == 32'(TICK_CYCLES - 1))
    begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // latest fundamentals, held between front end updates
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      meas_r <= '0;
    else if (i_meas_valid)
      meas_r <= i_meas;
  end

  // phases scaled to line-to-neutral nominal, so a full fault reads 100 percent
  assign sum3     = 18'(meas_r.ph_l1) + 18'(meas_r.ph_l2) + 18'(meas_r.ph_l3);
  assign calc_s   = sum3 / 18'sh0_0003;
  assign calc_mag = calc_s[17] ? 16'(-calc_s) : 16'(calc_s);

  always_comb
  begin
    src_eff = `SRC_NONE;
    case (src_sel_r)
      `SRC_CALC: src_eff = `SRC_CALC;
      `SRC_CH3:  src_eff = cfg_r[`CFG_CH3_RES] ? `SRC_CH3 : `SRC_NONE;
      `SRC_CH4:  src_eff = cfg_r[`CFG_CH4_RES] ? `SRC_CH4 : `SRC_NONE;
      default:
      begin
        if (cfg_r[`CFG_LN_CONN])
          src_eff = `SRC_CALC;
        else if (cfg_r[`CFG_CH3_RES])
          src_eff = `SRC_CH3;
        else if (cfg_r[`CFG_CH4_RES])
          src_eff = `SRC_CH4;
        else
          src_eff = `SRC_NONE;
      end
    endcase
  end

  always_comb
  begin
    meas_mag = 16'h0000;
    case (src_eff)
      `SRC_CALC: meas_mag = calc_mag;
      `SRC_CH3:  meas_mag = meas_r.ch3;
      `SRC_CH4:  meas_mag = meas_r.ch4;
      default:   meas_mag = 16'h0000;
    endcase
  end

  assign thr_act  = thr_r[i_active_group];
  assign rel_lvl  = 16'((24'(thr_act) * `RESET_PCT) / `FULL_PCT);
  assign run_ok   = (mode_r != `MODE_OFF) && (src_eff != `SRC_NONE);
  assign blk_mode = (mode_r == `MODE_BLOCKED) || (mode_r == `MODE_TEST_BLK);
  assign forced   = cfg_r[`CFG_FORCE_EN] && (force_r != `FORCE_NORMAL);

  // hysteresis: rise above threshold, fall under the release level or at once with mode off or no source
  always_comb
  begin
    if (!run_ok)
      pick_nxt = 1'b0;
    else if (!pick_r)
      pick_nxt = meas_mag > thr_act;
    else
      pick_nxt = !(meas_mag < rel_lvl);
  end

  assign ratio_full = (24'(meas_mag) * `FULL_PCT) / 24'(thr_act);

  // inverse time with unit exponent; a full power law would cost a big datapath
  assign idmt_q = (24'(k_r) * `K_TO_STEPS * `FULL_PCT) / 24'(ratio_r - 16'h0064);

  always_comb
  begin
    if (!dly_type_r)
      expect_nxt = dly_r;
    else if (ratio_r > 16'h0064)
      expect_nxt = (idmt_q > `MAX_STEPS) ? 20'(`MAX_STEPS) : 20'(idmt_q);
    else
      expect_nxt = 20'(`MAX_STEPS);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      pick_r  <= 1'b0;
      ratio_r <= 16'h0000;
    end
    else if (tick_r)
    begin
      pick_r  <= pick_nxt;
      if (!run_ok)
        ratio_r <= 16'h0000;
      else
        ratio_r <= (ratio_full > `RATIO_MAX) ? 16'(`RATIO_MAX) : 16'(ratio_full);
    end
  end

  // operate timer, stepped once per tick
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_r   <= nov_pkg::ST_IDLE;
      elapsed_r <= 20'h0_0000;
    end
    else if (tick_r)
    begin
      case (state_r)
        nov_pkg::ST_IDLE:
        begin
          elapsed_r <= 20'h0_0000;
          if (pick_nxt && !blk_mode)
            state_r <= (expect_nxt == 20'h0_0000) ? nov_pkg::ST_TRIPPED : nov_pkg::ST_COUNT;
        end
        nov_pkg::ST_COUNT:
        begin
          if (!pick_nxt || blk_mode)
          begin
            state_r   <= nov_pkg::ST_IDLE;
            elapsed_r <= 20'h0_0000;
          end
          else
          begin
            elapsed_r <= elapsed_r + 20'h0_0001;
            if (elapsed_r + 20'h0_0001 >= expect_nxt)
              state_r <= nov_pkg::ST_TRIPPED;
          end
        end
        default:
        begin
          if (!pick_nxt || blk_mode)
            state_r <= nov_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      remain_r <= 20'h0_0000;
    else if (state_r == nov_pkg::ST_COUNT && expect_nxt > elapsed_r)
      remain_r <= expect_nxt - elapsed_r;
    else
      remain_r <= 20'h0_0000;
  end

  assign start_nxt   = forced ? (force_r == `FORCE_START || force_r == `FORCE_TRIP)
                              : (state_r != nov_pkg::ST_IDLE);
  assign trip_nxt    = forced ? (force_r == `FORCE_TRIP) : (state_r == nov_pkg::ST_TRIPPED);
  assign blocked_nxt = forced ? (force_r == `FORCE_BLOCKED) : (pick_r && blk_mode);

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_start       <= 1'b0;
      o_trip        <= 1'b0;
      o_blocked     <= 1'b0;
      o_test        <= 1'b0;
      o_no_residual <= 1'b0;
      src_now_r     <= `SRC_NONE;
    end
    else
    begin
      o_start       <= start_nxt;
      o_trip        <= trip_nxt;
      o_blocked     <= blocked_nxt;
      o_test        <= (mode_r == `MODE_TEST) || (mode_r == `MODE_TEST_BLK);
      o_no_residual <= (src_eff == `SRC_NONE);
      src_now_r     <= src_eff;
    end
  end

  // static settings: one copy each, never indexed by setting group
  assign src_ok = !((i_bus.wdata[1:0] == `SRC_CH3 && !cfg_r[`CFG_CH3_RES]) ||
                    (i_bus.wdata[1:0] == `SRC_CH4 && !cfg_r[`CFG_CH4_RES]));

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      mode_r    <= `MODE_ON;
      force_r   <= `FORCE_NORMAL;
      src_sel_r <= `SRC_AUTO;
      cfg_r     <= 4'h0;
    end
    else if (i_bus.wr)
    begin
      if (i_bus.addr == `OFS_MODE && i_bus.wdata[2:0] <= `MODE_OFF)
        mode_r <= i_bus.wdata[2:0];
      else if (i_bus.addr == `OFS_FORCE)
        force_r <= i_bus.wdata[1:0];
      else if (i_bus.addr == `OFS_SRC && src_ok)
        src_sel_r <= i_bus.wdata[1:0];
      else if (i_bus.addr == `OFS_CFG)
        cfg_r <= i_bus.wdata[3:0];
    end
  end

  // threshold per setting group, timing shared; out-of-range thresholds are dropped
  assign wr_thr = i_bus.wr && (i_bus.addr[7:5] == `THR_PAGE);
  assign thr_ok = (i_bus.wdata[15:0] >= `THR_MIN) && (i_bus.wdata[15:0] <= `THR_MAX);

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      dly_type_r <= 1'b0;
      dly_r      <= `DLY_DEF;
      k_r        <= `K_DEF;
      for (int g = 0; g < 8; g++)
        thr_r[g] <= `THR_DEF;
    end
    else if (i_bus.wr)
    begin
      if (wr_thr && thr_ok)
        thr_r[i_bus.addr[4:2]] <= i_bus.wdata[15:0];
      else if (i_bus.addr == `OFS_DLY_TYPE)
        dly_type_r <= i_bus.wdata[0];
      else if (i_bus.addr == `OFS_DLY && i_bus.wdata[19:0] <= 20'(`MAX_STEPS))
        dly_r <= i_bus.wdata[19:0];
      else if (i_bus.addr == `OFS_KDIAL)
        k_r <= i_bus.wdata[15:0];
    end
  end

  // rising edges of the status outputs are the interrupt events
  assign ev[`IRQ_START] = start_nxt && !o_start;
  assign ev[`IRQ_TRIP]  = trip_nxt && !o_trip;
  assign ev[`IRQ_BLOCK] = blocked_nxt && !o_blocked;
  assign ev[`IRQ_NORES] = (src_eff == `SRC_NONE) && !o_no_residual;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      istat_r <= 4'h0;
      imask_r <= 4'h0;
      o_irq   <= 1'b0;
    end
    else
    begin
      // set wins over a same-cycle clear
      if (i_bus.wr && i_bus.addr == `OFS_ISTAT)
        istat_r <= (istat_r & ~i_bus.wdata[3:0]) | ev;
      else
        istat_r <= istat_r | ev;
      if (i_bus.wr && i_bus.addr == `OFS_IMASK)
        imask_r <= i_bus.wdata[3:0];
      o_irq <= |(istat_r & imask_r);
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (i_bus.addr == `OFS_MODE)
      rd_val = {29'h0, mode_r};
    else if (i_bus.addr == `OFS_FORCE)
      rd_val = {30'h0, force_r};
    else if (i_bus.addr == `OFS_SRC)
      rd_val = {30'h0, src_sel_r};
    else if (i_bus.addr == `OFS_CFG)
      rd_val = {28'h0, cfg_r};
    else if (i_bus.addr == `OFS_DLY_TYPE)
      rd_val = {31'h0, dly_type_r};
    else if (i_bus.addr == `OFS_DLY)
      rd_val = {12'h0, dly_r};
    else if (i_bus.addr == `OFS_KDIAL)
      rd_val = {16'h0, k_r};
    else if (i_bus.addr == `OFS_STATUS)
      rd_val = {21'h0, mode_r, src_now_r, o_no_residual, o_test, o_blocked, o_trip,
                o_start, pick_r};
    else if (i_bus.addr == `OFS_RATIO)
      rd_val = {16'h0, ratio_r};
    else if (i_bus.addr == `OFS_REMAIN)
      rd_val = {12'h0, remain_r};
    else if (i_bus.addr == `OFS_EXPECT)
      rd_val = {12'h0, expect_nxt};
    else if (i_bus.addr == `OFS_ISTAT)
      rd_val = {28'h0, istat_r};
    else if (i_bus.addr == `OFS_IMASK)
      rd_val = {28'h0, imask_r};
    else if (i_bus.addr[7:5] == `THR_PAGE)
      rd_val = {16'h0, thr_r[i_bus.addr[4:2]]};
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_rdata <= 32'h0000_0000;
    else
      o_rdata <= i_bus.rd ? rd_val : 32'h0000_0000;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_pick_tick;
    tick_r && !pick_r && state_r == nov_pkg::ST_IDLE && run_ok && !blk_mode && !forced &&
    meas_mag > thr_act && expect_nxt != 20'h0_0000;
  endsequence
  sequence s_quiet;
    !i_bus.wr;
  endsequence

  property p_pickup_start;
    s_pick_tick ##0 s_quiet ##1 s_quiet |=> o_start;
  endproperty
  a_pickup_start: assert property (p_pickup_start) else $error("no start after pick-up");

  property p_hold_above_release;
    tick_r && pick_r && run_ok && meas_mag >= rel_lvl |=> pick_r;
  endproperty
  a_hold_above_release: assert property (p_hold_above_release)
    else $error("released above release level");

  property p_release_below;
    tick_r && pick_r && meas_mag < rel_lvl |=> !pick_r;
  endproperty
  a_release_below: assert property (p_release_below) else $error("no release");

  property p_tick_only;
    !tick_r |=> $stable(pick_r) && $stable(ratio_r);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("pick-up moved off tick");

  property p_src_refused;
    i_bus.wr && i_bus.addr == `OFS_SRC && i_bus.wdata[1:0] == `SRC_CH3 &&
    !cfg_r[`CFG_CH3_RES] |=> $stable(src_sel_r);
  endproperty
  a_src_refused: assert property (p_src_refused) else $error("channel choice taken");

  property p_thr_write;
    wr_thr && thr_ok && i_bus.addr[4:2] == i_active_group ##1 i_active_group ==
    $past(i_active_group) |-> thr_act == $past(i_bus.wdata[15:0]);
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold not stored");

  property p_no_residual;
    src_sel_r == `SRC_AUTO && cfg_r[2:0] == 3'h0 |=> o_no_residual;
  endproperty
  a_no_residual: assert property (p_no_residual) else $error("missing no-residual");

  property p_force_trip;
    cfg_r[`CFG_FORCE_EN] && force_r == `FORCE_TRIP |=> o_trip && o_start;
  endproperty
  a_force_trip: assert property (p_force_trip) else $error("force trip ignored");

  // a magnitude at or over the threshold must read at least unity
  property p_ratio_unity;
    tick_r && run_ok && meas_mag >= thr_act |=> ratio_r >= 16'h0064;
  endproperty
  a_ratio_unity: assert property (p_ratio_unity) else $error("ratio below one");

  property p_remain_count;
    !tick_r && !$past(tick_r) && state_r == nov_pkg::ST_COUNT &&
    $past(state_r) == nov_pkg::ST_COUNT && !dly_type_r && !$past(dly_type_r) &&
    $stable(dly_r) |=> $stable(remain_r);
  endproperty
  a_remain_count: assert property (p_remain_count) else $error("remaining moved");

  property p_irq_level;
    ##1 o_irq == |($past(istat_r) & $past(imask_r));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq mismatch");
endmodule

// *** verif/meas_model.sv ***
// measurement front end model feeding the residual overvoltage stage
`timescale 1ns/1ps
module meas_model #(
  parameter int PERIOD = 7
) (
  // clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_nrst,
  // values the bench wants delivered
  input  wire nov_pkg::meas_t i_val,
  // towards the stage
  output nov_pkg::meas_t      o_meas,
  output logic                o_meas_valid
);
  int cnt;
  // sample only holds in the valid cycle; junk between so stale latching shows
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      cnt          <= 0;
      o_meas_valid <= 1'b0;
      o_meas       <= '0;
    end
    else
    begin
      cnt          <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_meas_valid <= (cnt == 0);
      o_meas       <= (cnt == 0) ? i_val : ~o_meas;
    end
  end
endmodule

// *** verif/tb_top.sv ***
// self-checking bench of the residual overvoltage stage
`timescale 1ns/1ps
`include "nov_params.svh"
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module tb_top;
  localparam int TICK = 20;
  logic              i_clk         = 1'b0;
  logic              i_nrst        = 1'b0;
  nov_pkg::bus_req_t i_bus         = '0;
  logic [2:0]        grp           = 3'h0;
  nov_pkg::meas_t    val           = '0;
  nov_pkg::meas_t    meas;
  logic              meas_valid;
  logic [31:0]       o_rdata;
  logic              o_start;
  logic              o_trip;
  logic              o_blocked;
  logic              o_test;
  logic              o_no_residual;
  logic              o_irq;
  int                fail_count    = 0;
  int                comparisons   = 0;
  logic [31:0]       seed          = 32'h0000_a92f;
  logic [31:0]       rd;
  logic              picked        = 1'b0;
  int                k;
  int                r;
  int                a;
  int                corner [5]    = '{2000, 2020, 1960, 1940, 1920};

  always #5 i_clk = ~i_clk;

  residual_overvoltage_stage #(.TICK_CYCLES(TICK)) dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_meas(meas), .i_meas_valid(meas_valid), .i_active_group(grp),
    .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked), .o_test(o_test),
    .o_no_residual(o_no_residual), .o_irq(o_irq));

  meas_model fe (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_val(val), .o_meas(meas), .o_meas_valid(meas_valid));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [31:0] exp_ratio(input int m, input int t);
    int q;
    q = m * 100 / t;
    return (q > 25000) ? 32'h0000_61A8 : 32'(q);
  endfunction

  // hysteresis: hold until below 97 percent of the threshold
  function automatic logic exp_pick(input logic p, input int m, input int t);
    return (m > t) || (p && !(m * 100 < t * 97));
  endfunction

  function automatic logic [7:0] thr_a(input logic [2:0] g);
    return {`THR_PAGE, g, 2'h0};
  endfunction

  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    @(posedge i_clk);
    i_bus <= '0;
  endtask

  task automatic rdr(input logic [7:0] ad, output logic [31:0] d);
    @(posedge i_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 32'h0};
    @(posedge i_clk);
    i_bus <= '0;
    #1 d = o_rdata;
  endtask

  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge i_clk);
    #1;
  endtask

  // waits for start (sel 0) or trip (sel 1)
  task automatic wait_for(input bit sel, input int lim);
    int n;
    n = 0;
    while ((sel ? o_trip : o_start) !== 1'b1 && n < lim)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    if ((sel ? o_trip : o_start) !== 1'b1)
    begin
      fail_count++;
      $display("Error wait expected 1 seen %0h", sel ? o_trip : o_start);
      finish_test();
    end
  endtask

  task automatic set_calc(input int m, input int d);
    @(posedge i_clk);
    val.ph_l1 <= 16'(m + d);
    val.ph_l2 <= 16'(m - d);
    val.ph_l3 <= 16'(m);
  endtask

  initial
  begin
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    #1;
    `CHK("no_residual", 1'b1, o_no_residual);
    rdr(`OFS_ISTAT, rd);
    `CHK("no_residual event", 1'b1, rd[3]);
    rdr(`OFS_MODE, rd);
    `CHK("mode", 32'h0, rd);
    rdr(`OFS_FORCE, rd);
    `CHK("force", 32'h0, rd);
    rdr(thr_a(3'h0), rd);
    `CHK("thr", 32'(`THR_DEF), rd);
    wr(`OFS_SRC, 32'h2);
    rdr(`OFS_SRC, rd);
    `CHK("src", 32'h0, rd);
    wr(`OFS_CFG, 32'h4);
    rdr(`OFS_STATUS, rd);
    `CHK("measuring", 2'h1, rd[7:6]);
    `CHK("no_residual", 1'b0, o_no_residual);
    wr(`OFS_SRC, 32'h1);
    rdr(`OFS_SRC, rd);
    `CHK("src", 32'h1, rd);
    // corner levels around both thresholds first, then random levels
    for (k = 0; k < 12; k++)
    begin
      seed = xs(seed);
      r = (k < 5) ? corner[k] : 20 * (int'(seed[8:0]) % 450 + 1);
      a = int'(seed[24:16]);
      set_calc(r, a);
      ticks(3);
      picked = exp_pick(picked, r, 2000);
      rdr(`OFS_RATIO, rd);
      `CHK("ratio", exp_ratio(r, 2000), rd);
      rdr(`OFS_STATUS, rd);
      `CHK("pickup", picked, rd[0]);
    end
    set_calc(0, 0);
    ticks(3);
    wr(`OFS_ISTAT, 32'hF);
    wr(thr_a(3'h1), 32'h3E8);
    wr(thr_a(3'h1), 32'h63);
    rdr(thr_a(3'h1), rd);
    `CHK("thr", 32'h3E8, rd);
    @(posedge i_clk);
    grp <= 3'h1;
    rdr(`OFS_SRC, rd);
    `CHK("src", 32'h1, rd);
    set_calc(1500, 7);
    wait_for(1'b0, 4 * TICK);
    rdr(`OFS_REMAIN, rd);
    `CHK("remain", 1'b1, rd > 0 && rd <= 8);
    rdr(`OFS_EXPECT, rd);
    `CHK("expect", 32'h8, rd);
    wait_for(1'b1, 12 * TICK);
    rdr(`OFS_ISTAT, rd);
    `CHK("istat", 2'h3, rd[1:0]);
    `CHK("irq", 1'b0, o_irq);
    wr(`OFS_IMASK, 32'h2);
    repeat (2) @(posedge i_clk);
    #1 `CHK("irq", 1'b1, o_irq);
    wr(`OFS_ISTAT, 32'h2);
    repeat (2) @(posedge i_clk);
    #1 `CHK("irq", 1'b0, o_irq);
    wr(`OFS_DLY_TYPE, 32'h1);
    ticks(2);
    rdr(`OFS_EXPECT, rd);
    `CHK("expect", 32'h14, rd);
    set_calc(2000, 3);
    ticks(3);
    rdr(`OFS_EXPECT, rd);
    `CHK("expect", 32'hA, rd);
    for (k = 0; k < 6; k++)
    begin
      wr(`OFS_MODE, 32'(k));
      ticks(3);
      rdr(`OFS_STATUS, rd);
      `CHK("mode now", (k > 4) ? 3'h4 : 3'(k), rd[10:8]);
      `CHK("blocked", k == 1 || k == 3, o_blocked);
      `CHK("test", k == 2 || k == 3, o_test);
    end
    wr(`OFS_FORCE, 32'h1);
    ticks(1);
    `CHK("start", 1'b0, o_start);
    wr(`OFS_CFG, 32'hC);
    for (k = 0; k < 4; k++)
    begin
      wr(`OFS_FORCE, 32'(k));
      ticks(1);
      `CHK("start", k == 1 || k == 2, o_start);
      `CHK("trip", k == 2, o_trip);
      `CHK("blocked", k == 3, o_blocked);
    end
    wr(`OFS_FORCE, 32'h0);
    wr(`OFS_MODE, 32'h0);
    wr(`OFS_CFG, 32'h2);
    rdr(`OFS_STATUS, rd);
    `CHK("measuring", 2'h1, rd[7:6]);
    wr(`OFS_SRC, 32'h3);
    rdr(`OFS_SRC, rd);
    `CHK("src", 32'h3, rd);
    @(posedge i_clk);
    val.ch4 <= 16'h7530;
    wr(thr_a(3'h1), 32'h64);
    ticks(3);
    rdr(`OFS_RATIO, rd);
    `CHK("ratio", exp_ratio(30000, 100), rd);
    rdr(`OFS_STATUS, rd);
    `CHK("measuring", 2'h3, rd[7:6]);
    wr(`OFS_CFG, 32'h0);
    ticks(1);
    `CHK("no_residual", 1'b1, o_no_residual);
    wr(`OFS_CFG, 32'h1);
    wr(`OFS_SRC, 32'h2);
    rdr(`OFS_SRC, rd);
    `CHK("src", 32'h2, rd);
    // reset in mid-run must bring back the static defaults
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    #1 `CHK("no_residual", 1'b1, o_no_residual);
    rdr(`OFS_SRC, rd);
    `CHK("src", 32'h0, rd);
    rdr(thr_a(3'h1), rd);
    `CHK("thr", 32'(`THR_DEF), rd);
    finish_test();
  end
endmodule
